// [core/lcd_segment_driver_cfg.svh]
// constants for the lcd segment driver
`ifndef LCD_SEGMENT_DRIVER_CFG_SVH
`define LCD_SEGMENT_DRIVER_CFG_SVH
`define RAM_BANK_SELECT_ADDR   8'h04
`define RAM_BANK_SELECT_RESET  8'h00
`define DISP_BANK              8'h01
`define DISP_FIRST_ADDR        8'h40
`define DISP_LAST_ADDR         8'h68
`define DISP_WORDS             41
`define SEG_COUNT              41
`define LOGIC_SEG_COUNT        24
`define SYS_DIV                4
`endif

// [core/lcd_segment_driver_pkg.sv]
// types for the lcd segment driver
`default_nettype none
package lcd_segment_driver_pkg;
  typedef enum logic [1:0] {
    DUTY_HALF    = 2'h0,
    DUTY_THIRD   = 2'h1,
    DUTY_QUARTER = 2'h2
  } duty_t;
  typedef enum logic [1:0] {
    SRC_SYS_DIV4 = 2'h0,
    SRC_RTC_OSC  = 2'h1,
    SRC_WDT_OSC  = 2'h2
  } clk_source_t;
  typedef enum logic [2:0] {
    SCAN_IDLE = 3'b001,
    SCAN_RUN  = 3'b010,
    SCAN_HOLD = 3'b100
  } scan_state_t;
endpackage : lcd_segment_driver_pkg
`default_nettype wire

// [core/lcd_segment_driver.sv]
// lcd display memory and multiplexed segment/common scanner
`include "lcd_segment_driver_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module lcd_segment_driver #(
  parameter lcd_segment_driver_pkg::duty_t       DUTY         = lcd_segment_driver_pkg::DUTY_QUARTER,
  parameter lcd_segment_driver_pkg::clk_source_t CLK_SOURCE   = lcd_segment_driver_pkg::SRC_SYS_DIV4,
  parameter logic [2:0]                          LCD_DIV_SEL  = 3'h0,
  parameter bit                                  RUN_IN_HALT  = 1'b1,
  parameter bit                                  THIRD_BIAS   = 1'b1,
  parameter bit                                  CHARGE_PUMP  = 1'b0,
  parameter bit                                  HIGH_CURRENT = 1'b0,
  parameter logic [1:0]                          LOGIC_BYTES  = 2'h0,
  parameter logic [7:0]                          LOGIC_PINS   = 8'h00
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [7:0]            mem_addr,
  input  wire logic                  mem_indirect_mp1,
  input  wire logic                  mem_wr,
  input  wire logic                  mem_rd,
  input  wire logic [7:0]            mem_wdata,
  output var  logic [7:0]            mem_rdata,
  output var  logic                  mem_hit_display,
  output var  logic                  mem_hit_bank_select,
  input  wire logic                  halt,
  input  wire logic                  rtc_osc,
  input  wire logic                  wdt_osc,
  output var  logic [3:0]            common_active,
  output var  logic [`SEG_COUNT-1:0] segment_on,
  output var  logic [`SEG_COUNT-1:0] segment_is_logic,
  output var  logic [1:0]            common_count_m1,
  output var  logic                  bias_third,
  output var  logic                  bias_charge_pump,
  output var  logic                  bias_high_current,
  output var  logic [7:0]            ram_bank_select
);
  logic [7:0]                disp_mem [`DISP_WORDS];
  logic [7:0]                bank_reg;
  logic                      rtc_s1;
  logic                      rtc_s2;
  logic                      rtc_s3;
  logic                      wdt_s1;
  logic                      wdt_s2;
  logic                      wdt_s3;
  logic                      halt_s1;
  logic                      halt_s2;
  logic [1:0]                sys_cnt;
  logic [7:0]                div_cnt;
  logic [1:0]                slot;
  lcd_segment_driver_pkg::scan_state_t state;
  lcd_segment_driver_pkg::scan_state_t next_state;

  // address decode
  wire        in_window   = (mem_addr >= `DISP_FIRST_ADDR) && (mem_addr <= `DISP_LAST_ADDR);
  wire        bank_is_one = (bank_reg == `DISP_BANK);
  wire        disp_sel    = in_window && bank_is_one && mem_indirect_mp1;
  wire        bank_sel    = (mem_addr == `RAM_BANK_SELECT_ADDR);
  wire [7:0]  disp_off    = mem_addr - `DISP_FIRST_ADDR;
  wire [5:0]  disp_idx    = disp_off[5:0];
  wire        disp_wr     = disp_sel && mem_wr;
  wire        bank_wr     = bank_sel && mem_wr;
  wire [7:0]  next_rdata  = disp_sel ? disp_mem[disp_idx] : (bank_sel ? bank_reg : 8'h00);

  // source clock tick: system clock/4 or a synchronised oscillator edge
  wire        rtc_rise = rtc_s2 && !rtc_s3;
  wire        wdt_rise = wdt_s2 && !wdt_s3;
  wire        src_tick = (CLK_SOURCE == lcd_segment_driver_pkg::SRC_RTC_OSC) ? rtc_rise :
                         (CLK_SOURCE == lcd_segment_driver_pkg::SRC_WDT_OSC) ? wdt_rise :
                         (sys_cnt == 2'(`SYS_DIV - 1));
  // divider 4 << sel, sel 0..6 gives /4 .. /256
  wire [7:0]  div_last = 8'((9'h004 << LCD_DIV_SEL) - 9'h001);
  wire        run_ok   = RUN_IN_HALT || !halt_s2;
  wire        lcd_tick = src_tick && (div_cnt == div_last);
  wire [1:0]  slot_last = (DUTY == lcd_segment_driver_pkg::DUTY_HALF)  ? 2'h1 :
                          (DUTY == lcd_segment_driver_pkg::DUTY_THIRD) ? 2'h2 : 2'h3;
  wire        quad     = (DUTY == lcd_segment_driver_pkg::DUTY_QUARTER);

  always_comb
  begin
    next_state = state;
    case (state)
      lcd_segment_driver_pkg::SCAN_IDLE: next_state = lcd_segment_driver_pkg::SCAN_RUN;
      lcd_segment_driver_pkg::SCAN_RUN:  if (!run_ok) next_state = lcd_segment_driver_pkg::SCAN_HOLD;
      lcd_segment_driver_pkg::SCAN_HOLD: if (run_ok) next_state = lcd_segment_driver_pkg::SCAN_RUN;
      default:                           next_state = lcd_segment_driver_pkg::SCAN_IDLE;
    endcase
  end
  wire running = (state == lcd_segment_driver_pkg::SCAN_RUN);

  // segment data for the current slot, logic pins from bit 0
  logic [`SEG_COUNT-1:0] next_seg;
  logic [`SEG_COUNT-1:0] logic_mask;
  always_comb
  begin
    for (int i = 0; i < `SEG_COUNT; i++)
    begin
      logic_mask[i] = 1'b0;
      if (i < 8) logic_mask[i] = LOGIC_BYTES[0];
      else if (i < 16) logic_mask[i] = LOGIC_BYTES[1];
      else if (i < `LOGIC_SEG_COUNT) logic_mask[i] = LOGIC_PINS[3'(i - 16)];
      // logic pins ignore halt so a static output keeps its level
      if (logic_mask[i]) next_seg[i] = disp_mem[i][0];
      else next_seg[i] = disp_mem[i][slot] && running;
    end
    if (quad) next_seg[`SEG_COUNT-1] = 1'b0;
  end
  wire [3:0] next_com = running ? (4'h1 << slot) : 4'h0;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rtc_s1  <= 1'b0;
      rtc_s2  <= 1'b0;
      rtc_s3  <= 1'b0;
      wdt_s1  <= 1'b0;
      wdt_s2  <= 1'b0;
      wdt_s3  <= 1'b0;
      halt_s1 <= 1'b0;
      halt_s2 <= 1'b0;
    end
    else
    begin
      rtc_s1  <= rtc_osc;
      rtc_s2  <= rtc_s1;
      rtc_s3  <= rtc_s2;
      wdt_s1  <= wdt_osc;
      wdt_s2  <= wdt_s1;
      wdt_s3  <= wdt_s2;
      halt_s1 <= halt;
      halt_s2 <= halt_s1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys_cnt <= 2'h0;
      div_cnt <= 8'h00;
      slot    <= 2'h0;
      state   <= lcd_segment_driver_pkg::SCAN_IDLE;
    end
    else
    begin
      sys_cnt <= sys_cnt + 2'h1;
      state   <= next_state;
      if (src_tick && running)
        div_cnt <= lcd_tick ? 8'h00 : div_cnt + 8'h01;
      if (lcd_tick && running)
        slot <= (slot == slot_last) ? 2'h0 : slot + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bank_reg <= `RAM_BANK_SELECT_RESET;
      for (int i = 0; i < `DISP_WORDS; i++)
        disp_mem[i] <= 8'h00;
    end
    else
    begin
      if (bank_wr)
        bank_reg <= mem_wdata;
      if (disp_wr)
        disp_mem[disp_idx] <= mem_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_rdata           <= 8'h00;
      mem_hit_display     <= 1'b0;
      mem_hit_bank_select <= 1'b0;
      common_active       <= 4'h0;
      segment_on          <= '0;
      segment_is_logic    <= '0;
      common_count_m1     <= 2'h0;
      bias_third          <= 1'b0;
      bias_charge_pump    <= 1'b0;
      bias_high_current   <= 1'b0;
      ram_bank_select     <= `RAM_BANK_SELECT_RESET;
    end
    else
    begin
      mem_rdata           <= mem_rd ? next_rdata : 8'h00;
      // general ram answers when this is low
      mem_hit_display     <= disp_sel && (mem_rd || mem_wr);
      mem_hit_bank_select <= bank_sel && (mem_rd || mem_wr);
      common_active       <= next_com;
      segment_on          <= next_seg;
      segment_is_logic    <= logic_mask;
      common_count_m1     <= slot_last;
      bias_third          <= THIRD_BIAS;
      bias_charge_pump    <= CHARGE_PUMP;
      bias_high_current   <= HIGH_CURRENT && !CHARGE_PUMP;
      ram_bank_select     <= bank_reg;
    end
  end

  property p_direct_blocked;
    @(posedge clk) disable iff (!rst_n)
      (mem_wr && !mem_indirect_mp1) |=> !mem_hit_display;
  endproperty
  a_direct_blocked: assert property (p_direct_blocked) else $error("direct access hit display");

  property p_bank_route;
    @(posedge clk) disable iff (!rst_n)
      (mem_wr && in_window && mem_indirect_mp1 && bank_reg != 8'h01) |=> !mem_hit_display;
  endproperty
  a_bank_route: assert property (p_bank_route) else $error("wrong bank hit display");

  property p_disp_hit;
    @(posedge clk) disable iff (!rst_n)
      (mem_wr && in_window && mem_indirect_mp1 && bank_reg == 8'h01) |=> mem_hit_display;
  endproperty
  a_disp_hit: assert property (p_disp_hit) else $error("bank one write missed display");

  property p_one_common;
    @(posedge clk) disable iff (!rst_n) $onehot0(common_active);
  endproperty
  a_one_common: assert property (p_one_common) else $error("more than one common active");

  property p_no_third_half;
    @(posedge clk) disable iff (!rst_n)
      (DUTY == lcd_segment_driver_pkg::DUTY_HALF) |-> common_active[3:2] == 2'h0;
  endproperty
  a_no_third_half: assert property (p_no_third_half) else $error("extra common in half duty");

  property p_last_seg_common;
    @(posedge clk) disable iff (!rst_n) quad |-> !segment_on[`SEG_COUNT-1];
  endproperty
  a_last_seg_common: assert property (p_last_seg_common) else $error("last segment driven as segment");

  property p_halt_stop;
    @(posedge clk) disable iff (!rst_n)
      (!RUN_IN_HALT && halt_s2 && running) |=> ##1 common_active == 4'h0;
  endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("driver kept running in halt");

  property p_slot_advance;
    @(posedge clk) disable iff (!rst_n)
      (lcd_tick && running && slot != slot_last) |=> slot == $past(slot) + 2'h1;
  endproperty
  a_slot_advance: assert property (p_slot_advance) else $error("slot did not advance");

  property p_pixel;
    @(posedge clk) disable iff (!rst_n)
      (running && !logic_mask[0]) |=> segment_on[0] == $past(disp_mem[0][slot]);
  endproperty
  a_pixel: assert property (p_pixel) else $error("segment 0 mismatches memory");

  property p_logic_static;
    @(posedge clk) disable iff (!rst_n)
      logic_mask[0] |=> segment_on[0] == $past(disp_mem[0][0]);
  endproperty
  a_logic_static: assert property (p_logic_static) else $error("logic segment not bit 0");

  property p_hold_blank;
    @(posedge clk) disable iff (!rst_n)
      (state == lcd_segment_driver_pkg::SCAN_HOLD) |=> common_active == 4'h0;
  endproperty
  a_hold_blank: assert property (p_hold_blank) else $error("common driven while held");

  property p_read_refused;
    @(posedge clk) disable iff (!rst_n)
      (mem_rd && !disp_sel && !bank_sel) |=> mem_rdata == 8'h00;
  endproperty
  a_read_refused: assert property (p_read_refused) else $error("refused read returned data");

  property p_common_count;
    @(posedge clk) disable iff (!rst_n)
      running |=> common_count_m1 == slot_last;
  endproperty
  a_common_count: assert property (p_common_count) else $error("common count wrong");

  c_disp_write: cover property (@(posedge clk) disable iff (!rst_n) disp_wr);
  c_fourth_com: cover property (@(posedge clk) disable iff (!rst_n) common_active[3]);
  c_logic_seg:  cover property (@(posedge clk) disable iff (!rst_n) logic_mask[0] && segment_on[0]);
  c_slot_wrap:  cover property (@(posedge clk) disable iff (!rst_n) lcd_tick && slot == slot_last);
  c_halt:       cover property (@(posedge clk) disable iff (!rst_n) state == lcd_segment_driver_pkg::SCAN_HOLD);
endmodule : lcd_segment_driver
`default_nettype wire

// [tb/lcd_panel_model.sv]
// glass panel model: latches segment levels under each active common
`timescale 1ns/100ps
`default_nettype none
module lcd_panel_model (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [3:0]       common_active,
  input  wire logic [40:0]      segment_on,
  output var  logic [3:0][40:0] pixel,
  output var  logic [3:0]       common_seen
);
  // unknown pixels until a common is first scanned, like real glass
  always @(posedge clk)
  begin
    for (int k = 0; k < 4; k++)
    begin
      if (!rst_n)
        common_seen[k] <= 1'b0;
      else if (common_active[k] === 1'b1)
      begin
        pixel[k] <= segment_on;
        common_seen[k] <= 1'b1;
      end
    end
  end
endmodule : lcd_panel_model
`default_nettype wire

// [tb/test_lcd_segment_driver.sv]
// self-checking bench for the lcd segment driver
`timescale 1ns/100ps
`default_nettype none
module test_lcd_segment_driver;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [7:0]            mem_addr = 8'h00;
  logic                  mem_indirect_mp1 = 1'b0;
  logic                  mem_wr = 1'b0;
  logic                  mem_rd = 1'b0;
  logic [7:0]            mem_wdata = 8'h00;
  logic [7:0]            mem_rdata;
  logic                  mem_hit_display;
  logic                  mem_hit_bank_select;
  logic [3:0]            common_active;
  logic [40:0]           segment_on;
  logic [40:0]           segment_is_logic;
  logic [1:0]            common_count_m1;
  logic                  bias_third;
  logic                  bias_charge_pump;
  logic                  bias_high_current;
  logic [7:0]            ram_bank_select;
  logic [3:0][40:0]      pixel;
  logic [3:0]            common_seen;
  logic                  halt = 1'b0;
  logic                  rtc_osc = 1'b0;
  logic [3:0]            alt_common_active;
  logic [40:0]           alt_segment_on;
  logic [40:0]           alt_segment_is_logic;
  logic [1:0]            alt_common_count_m1;
  logic                  alt_bias_third;
  logic                  alt_bias_charge_pump;
  logic                  alt_bias_high_current;
  logic [3:0]            alt_com_seen = 4'h0;
  int                    n_errors = 0;
  int                    n_tests = 0;
  int                    cycles = 0;

  always #5 clk = ~clk;

  lcd_segment_driver DUT (
    .clk(clk), .rst_n(rst_n), .mem_addr(mem_addr), .mem_indirect_mp1(mem_indirect_mp1),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_hit_display(mem_hit_display), .mem_hit_bank_select(mem_hit_bank_select),
    .halt(halt), .rtc_osc(rtc_osc), .wdt_osc(1'b0), .common_active(common_active),
    .segment_on(segment_on), .segment_is_logic(segment_is_logic), .common_count_m1(common_count_m1),
    .bias_third(bias_third), .bias_charge_pump(bias_charge_pump), .bias_high_current(bias_high_current),
    .ram_bank_select(ram_bank_select)
  );

  // half duty, rtc source, logic pins, stops in halt, charge pump bias
  lcd_segment_driver #(
    .DUTY(lcd_segment_driver_pkg::DUTY_HALF), .CLK_SOURCE(lcd_segment_driver_pkg::SRC_RTC_OSC),
    .RUN_IN_HALT(1'b0), .THIRD_BIAS(1'b0), .CHARGE_PUMP(1'b1), .HIGH_CURRENT(1'b1),
    .LOGIC_BYTES(2'h1), .LOGIC_PINS(8'h01)
  ) alt_dut (
    .clk(clk), .rst_n(rst_n), .mem_addr(mem_addr), .mem_indirect_mp1(mem_indirect_mp1),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(),
    .mem_hit_display(), .mem_hit_bank_select(),
    .halt(halt), .rtc_osc(rtc_osc), .wdt_osc(1'b0), .common_active(alt_common_active),
    .segment_on(alt_segment_on), .segment_is_logic(alt_segment_is_logic),
    .common_count_m1(alt_common_count_m1), .bias_third(alt_bias_third),
    .bias_charge_pump(alt_bias_charge_pump), .bias_high_current(alt_bias_high_current),
    .ram_bank_select()
  );

  lcd_panel_model panel (
    .clk(clk), .rst_n(rst_n), .common_active(common_active), .segment_on(segment_on),
    .pixel(pixel), .common_seen(common_seen)
  );

  // slow oscillator stand-in, one rising edge every four clocks
  always @(posedge clk)
  begin
    #1;
    rtc_osc = cycles[1];
    if (rst_n)
      alt_com_seen = alt_com_seen | alt_common_active;
  end

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // one access, strobe held over exactly one taking edge, answer sampled after it
  task automatic acc(input logic [7:0] a, input logic ind, input logic wr, input logic [7:0] d,
                     input logic [7:0] er, input logic ed, input logic eb);
    @(posedge clk);
    #1;
    mem_addr = a;
    mem_indirect_mp1 = ind;
    mem_wdata = d;
    mem_wr = wr;
    mem_rd = ~wr;
    @(posedge clk);
    #1;
    mem_wr = 1'b0;
    mem_rd = 1'b0;
    check("rdata", {56'h0, mem_rdata}, {56'h0, er});
    check("hit_display", {63'h0, mem_hit_display}, {63'h0, ed});
    check("hit_bank_select", {63'h0, mem_hit_bank_select}, {63'h0, eb});
  endtask : acc

  always @(posedge clk)
  begin
    cycles++;
    // whole sequence needs well under a thousand cycles
    if (cycles == 5000)
    begin
      n_errors++;
      $display("ERROR timeout expected 0 seen 1");
      conclude();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    check("reset bank", {56'h0, ram_bank_select}, 64'h0);
    check("reset commons", {60'h0, common_active}, 64'h0);
    #1;
    rst_n = 1'b1;
    acc(8'h04, 1'b0, 1'b1, 8'h01, 8'h00, 1'b0, 1'b1);
    acc(8'h04, 1'b0, 1'b0, 8'h00, 8'h01, 1'b0, 1'b1);
    check("bank", {56'h0, ram_bank_select}, 64'h1);
    acc(8'h40, 1'b1, 1'b1, 8'h05, 8'h00, 1'b1, 1'b0);
    acc(8'h68, 1'b1, 1'b1, 8'h0a, 8'h00, 1'b1, 1'b0);
    acc(8'h3f, 1'b1, 1'b1, 8'hff, 8'h00, 1'b0, 1'b0);
    acc(8'h69, 1'b1, 1'b1, 8'hff, 8'h00, 1'b0, 1'b0);
    acc(8'h41, 1'b0, 1'b1, 8'hff, 8'h00, 1'b0, 1'b0);
    acc(8'h41, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
    acc(8'h41, 1'b1, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0);
    acc(8'h68, 1'b1, 1'b0, 8'h00, 8'h0a, 1'b1, 1'b0);
    for (int b = 0; b < 3; b += 2)
    begin
      acc(8'h04, 1'b0, 1'b1, b[7:0], 8'h00, 1'b0, 1'b1);
      acc(8'h40, 1'b1, 1'b1, 8'hf0, 8'h00, 1'b0, 1'b0);
      acc(8'h40, 1'b1, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
    end
    acc(8'h04, 1'b0, 1'b1, 8'h01, 8'h00, 1'b0, 1'b1);
    acc(8'h40, 1'b1, 1'b0, 8'h00, 8'h05, 1'b1, 1'b0);
    repeat (300) @(posedge clk);
    #1;
    check("commons scanned", {60'h0, common_seen}, 64'hf);
    for (int k = 0; k < 4; k++)
    begin
      check("pixel seg0", {63'h0, pixel[k][0]}, {63'h0, k[0] ^ 1'b1});
    end
    check("common count", {62'h0, common_count_m1}, 64'h3);
    check("logic mask", {23'h0, segment_is_logic}, 64'h0);
    check("bias third", {63'h0, bias_third}, 64'h1);
    check("charge pump", {63'h0, bias_charge_pump}, 64'h0);
    check("high current", {63'h0, bias_high_current}, 64'h0);
    check("alt commons", {60'h0, alt_com_seen}, 64'h3);
    check("alt count", {62'h0, alt_common_count_m1}, 64'h1);
    check("alt logic mask", {23'h0, alt_segment_is_logic}, 64'h100ff);
    check("alt bias third", {63'h0, alt_bias_third}, 64'h0);
    check("alt charge pump", {63'h0, alt_bias_charge_pump}, 64'h1);
    check("alt high current", {63'h0, alt_bias_high_current}, 64'h0);
    // two sync stages, hold state, output flop
    halt = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check("halt commons", {60'h0, alt_common_active}, 64'h0);
    check("halt last_segment_output", {63'h0, alt_segment_on[40]}, 64'h0);
    check("logic seg0", {63'h0, alt_segment_on[0]}, 64'h1);
    check("logic seg1", {63'h0, alt_segment_on[1]}, 64'h0);
    check("run in halt", {63'h0, common_active != 4'h0}, 64'h1);
    conclude();
  end
endmodule : test_lcd_segment_driver
`default_nettype wire
